// ---- common/cil_pkg.sv ----
// Purpose: Shared types and constants for the conditional interlock and pilot air supervisor
// Assumes: AHB-Lite register access, 32-bit words, one clock
// Notes: Contract
// Contract
// - Condition off means its interlocks never trip
// - Five condition sets, A through E
// - Standby time before supervision starts
// - Each terminal selects one set only
// - One set may guard many terminals
// - Main switch off at startup: confirm
// - Main switch on after sync: check done
// - Purge start after check: purge, complete
// - Pilot switch open off, closed on
// - Pilot switch on after sync: done
// - Pilot check gates downstream pilot startup
// - Master drives regular interlock when ready
// - Pilot air loss: lockout, drop, alarm
// - Pilot switch never affects prepurge timing
// - Pilot check before or after purge
// - Module type gates available functions
// - Duplicate function: lowest terminal wins
package cil_pkg;
    // Module personality
    typedef enum logic [1:0] {
        TYPE_REGULAR = 2'b00,
        TYPE_ZONE = 2'b01,
        TYPE_SINGLE = 2'b10
    } mod_type_e;
    // Main air and prepurge sequence
    typedef enum logic [2:0] {
        M_IDLE = 3'b000,
        M_OFFOK = 3'b001,
        M_CHECKED = 3'b010,
        M_PURGING = 3'b011,
        M_PURGED = 3'b100
    } main_state_e;
    // Pilot air startup check
    typedef enum logic [1:0] {
        P_IDLE = 2'b00,
        P_OFFOK = 2'b01,
        P_DONE = 2'b10
    } pilot_state_e;
    // Monitor outputs travel together
    typedef struct packed {
        logic main_air_off_confirmed;
        logic main_air_check_done;
        logic purge_in_progress;
        logic purge_complete;
        logic pilot_air_off_confirmed;
        logic pilot_air_check_done;
        logic pilot_air_alarm;
    } mon_s;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_ASSIGN_LO = 8'h08;
    localparam logic [7:0] OFS_ASSIGN_HI = 8'h0C;
    localparam logic [7:0] OFS_COND_SRC = 8'h10;
    localparam logic [7:0] OFS_FUNC0 = 8'h14;
    localparam logic [7:0] OFS_FUNC1 = 8'h18;
    localparam logic [7:0] OFS_STANDBY = 8'h1C;
    localparam logic [7:0] OFS_PURGE = 8'h20;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
    localparam logic [7:0] OFS_CMD = 8'h2C;
    // Reset values and counts
    localparam logic [15:0] STANDBY_RST = 16'h0010;
    localparam logic [15:0] PURGE_RST = 16'h0020;
    localparam logic [3:0] IRQ_RST = 4'h0;
    localparam int NUM_SETS = 5;
    // Interrupt status bit positions
    localparam int IRQ_LOCKOUT = 0;
    localparam int IRQ_MAIN_DONE = 1;
    localparam int IRQ_PURGED = 2;
    localparam int IRQ_PILOT_DONE = 3;
endpackage : cil_pkg

// ---- hdl/interlock_supervisor.sv ----
// Purpose: Conditional interlock and pilot air supervisor with AHB-Lite registers
// Assumes: All terminal inputs synchronous to hclk
// Notes: Reads take one wait state, writes none
`timescale 1ns/1ps
module interlock_supervisor
#(
    parameter int N_IN = 16
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [N_IN-1:0] term_in,
    input wire logic startup,
    input wire logic main_air_sw,
    output cil_pkg::mon_s mon,
    output logic regular_interlock,
    output logic pilot_permit,
    output logic lockout,
    output logic irq
);
    // First terminal whose function bit is set, lowest number wins
    function automatic logic first_in(input logic [15:0] mask, input logic [N_IN-1:0] v);
        logic r;
        r = 1'b0;
        for (int i = N_IN - 1; i >= 0; i--)
        begin
            if (mask[i])
                r = v[i];
        end
        return r;
    endfunction : first_in

    // Software registers
    logic [1:0] mod_type;
    logic [47:0] assign_map; // Three-bit set code per terminal, 0 is none
    logic [19:0] cond_src; // Terminal index per condition set
    logic [31:0] func0; // Blower sync mask low, purge start mask high
    logic [31:0] func1; // Pilot sync mask low, pilot switch mask high
    logic [15:0] standby_time;
    logic [15:0] purge_time;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    // Bus pipeline
    logic wr_pend;
    logic rd_pend;
    logic [7:0] dp_addr;
    // Sequencers and counters
    cil_pkg::main_state_e main_st;
    cil_pkg::main_state_e next_main;
    cil_pkg::pilot_state_e pilot_st;
    cil_pkg::pilot_state_e next_pilot;
    logic [15:0] purge_cnt;
    logic [15:0] sb_cnt [cil_pkg::NUM_SETS];
    logic prev_done;
    logic prev_purged;
    logic prev_pdone;

    // Decoded function inputs
    wire logic blower_sync = first_in(func0[15:0], term_in);
    wire logic purge_start = first_in(func0[31:16], term_in);
    wire logic regular = (mod_type == cil_pkg::TYPE_REGULAR);
    wire logic pilot_sync = regular & first_in(func1[15:0], term_in);
    wire logic pilot_sw = regular & first_in(func1[31:16], term_in);

    // Condition set activity and supervision windows
    logic [cil_pkg::NUM_SETS-1:0] cond_on;
    logic [cil_pkg::NUM_SETS-1:0] supervise;
    logic [N_IN-1:0] term_trip;
    always_comb
    begin
        for (int k = 0; k < cil_pkg::NUM_SETS; k++)
        begin
            cond_on[k] = term_in[cond_src[4*k +: 4]];
            // Armed only once the standby count has run out
            supervise[k] = cond_on[k] & (sb_cnt[k] == standby_time);
        end
        for (int i = 0; i < N_IN; i++)
        begin
            // One code per terminal, so one set; many terminals may share it
            term_trip[i] = 1'b0;
            for (int k = 0; k < cil_pkg::NUM_SETS; k++)
            begin
                if (assign_map[3*i +: 3] == 3'(k + 1) && supervise[k] && !term_in[i])
                    term_trip[i] = 1'b1;
            end
        end
    end
    wire logic trip_now = |term_trip;

    // Pilot air lost after downstream pilot was released
    wire logic pilot_loss = regular_interlock & ~pilot_sw;
    wire logic lock_set = trip_now | pilot_loss;
    wire logic cmd_wr = wr_pend & (dp_addr == cil_pkg::OFS_CMD);
    // Reset only honoured once the cause has gone away
    wire logic lock_clr = cmd_wr & hwdata[0] & ~trip_now & ~(mon.pilot_air_alarm & ~pilot_sw);
    wire logic next_lockout = lock_set | (lockout & ~lock_clr);
    wire logic purge_last = (purge_cnt + 16'h0001 >= purge_time);

    // Main air check and prepurge sequencing
    always_comb
    begin
        next_main = main_st;
        case (main_st)
            cil_pkg::M_IDLE:
                if (startup && !main_air_sw)
                    next_main = cil_pkg::M_OFFOK;
            cil_pkg::M_OFFOK:
                if (blower_sync && main_air_sw)
                    next_main = cil_pkg::M_CHECKED;
            cil_pkg::M_CHECKED:
                if (purge_start && main_air_sw)
                    next_main = cil_pkg::M_PURGING;
            cil_pkg::M_PURGING:
                // Pilot switch has no part here; only purge start pauses
                if (purge_start && purge_last)
                    next_main = cil_pkg::M_PURGED;
            default:
                next_main = main_st;
        endcase
        if (!startup || next_lockout)
            next_main = cil_pkg::M_IDLE;
    end

    // Pilot air startup check, independent of purge progress
    always_comb
    begin
        next_pilot = pilot_st;
        case (pilot_st)
            cil_pkg::P_IDLE:
                if (startup && !pilot_sw)
                    next_pilot = cil_pkg::P_OFFOK;
            cil_pkg::P_OFFOK:
                // Host only syncs after seeing the off confirmation
                if (pilot_sync && pilot_sw)
                    next_pilot = cil_pkg::P_DONE;
            default:
                next_pilot = pilot_st;
        endcase
        if (!startup || next_lockout || !regular)
            next_pilot = cil_pkg::P_IDLE;
    end

    // Combustion permission, either check may finish first
    wire logic purged_n = (next_main == cil_pkg::M_PURGED);
    wire logic pdone_n = (next_pilot == cil_pkg::P_DONE);
    wire logic next_permit = purged_n & (pdone_n | ~regular) & ~next_lockout;
    wire logic next_ril = regular & purged_n & pdone_n & ~next_lockout;
    wire logic next_alarm = (pilot_loss | mon.pilot_air_alarm) & next_lockout;

    // Interrupt events and write-one-to-clear, set wins
    wire logic [3:0] irq_ev = {pdone_n & ~prev_pdone, purged_n & ~prev_purged,
        (next_main == cil_pkg::M_CHECKED) & ~prev_done, next_lockout & ~lockout};
    wire logic stat_wr = wr_pend & (dp_addr == cil_pkg::OFS_IRQ_STAT);
    wire logic [3:0] next_stat = irq_ev | (irq_stat & ~(stat_wr ? hwdata[3:0] : 4'h0));

    // Address phase decode
    wire logic take = hsel & hready & htrans[1];

    // Read mux, captured during the wait state so a prior write is visible
    logic [31:0] rd_mux;
    always_comb
    begin
        if (dp_addr == cil_pkg::OFS_CTRL)
            rd_mux = {30'h0, mod_type};
        else if (dp_addr == cil_pkg::OFS_STATUS)
            rd_mux = {19'h0, trip_now, supervise, pilot_st, main_st, mon.pilot_air_alarm, lockout};
        else if (dp_addr == cil_pkg::OFS_ASSIGN_LO)
            rd_mux = {8'h0, assign_map[23:0]};
        else if (dp_addr == cil_pkg::OFS_ASSIGN_HI)
            rd_mux = {8'h0, assign_map[47:24]};
        else if (dp_addr == cil_pkg::OFS_COND_SRC)
            rd_mux = {12'h0, cond_src};
        else if (dp_addr == cil_pkg::OFS_FUNC0)
            rd_mux = func0;
        else if (dp_addr == cil_pkg::OFS_FUNC1)
            rd_mux = func1;
        else if (dp_addr == cil_pkg::OFS_STANDBY)
            rd_mux = {16'h0, standby_time};
        else if (dp_addr == cil_pkg::OFS_PURGE)
            rd_mux = {16'h0, purge_time};
        else if (dp_addr == cil_pkg::OFS_IRQ_STAT)
            rd_mux = {28'h0, irq_stat};
        else if (dp_addr == cil_pkg::OFS_IRQ_MASK)
            rd_mux = {28'h0, irq_mask};
        else
            rd_mux = 32'h0; // Unmapped reads as zero
    end

    // Bus slave: writes zero wait, reads one wait state, always OKAY
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            dp_addr <= 8'h00;
            hreadyout <= 1'b1;
            hrdata <= 32'h0;
            hresp <= 1'b0;
        end
        else if (ce)
        begin
            wr_pend <= take & hwrite;
            rd_pend <= take & ~hwrite;
            hreadyout <= ~(take & ~hwrite);
            if (take)
                dp_addr <= haddr[7:0];
            if (rd_pend)
                hrdata <= rd_mux;
        end
    end

    // Configuration writes; hsize is word only and not checked
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mod_type <= cil_pkg::TYPE_REGULAR;
            assign_map <= 48'h0;
            cond_src <= 20'h0;
            func0 <= 32'h0;
            func1 <= 32'h0;
            standby_time <= cil_pkg::STANDBY_RST;
            purge_time <= cil_pkg::PURGE_RST;
            irq_mask <= cil_pkg::IRQ_RST;
        end
        else if (ce && wr_pend)
        begin
            if (dp_addr == cil_pkg::OFS_CTRL)
                mod_type <= hwdata[1:0];
            else if (dp_addr == cil_pkg::OFS_ASSIGN_LO)
                assign_map[23:0] <= hwdata[23:0];
            else if (dp_addr == cil_pkg::OFS_ASSIGN_HI)
                assign_map[47:24] <= hwdata[23:0];
            else if (dp_addr == cil_pkg::OFS_COND_SRC)
                cond_src <= hwdata[19:0];
            else if (dp_addr == cil_pkg::OFS_FUNC0)
                func0 <= hwdata;
            else if (dp_addr == cil_pkg::OFS_FUNC1)
                func1 <= hwdata;
            else if (dp_addr == cil_pkg::OFS_STANDBY)
                standby_time <= hwdata[15:0];
            else if (dp_addr == cil_pkg::OFS_PURGE)
                purge_time <= hwdata[15:0];
            else if (dp_addr == cil_pkg::OFS_IRQ_MASK)
                irq_mask <= hwdata[3:0];
        end
    end

    // Standby counters restart whenever their condition drops
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int k = 0; k < cil_pkg::NUM_SETS; k++)
                sb_cnt[k] <= 16'h0;
        end
        else if (ce)
        begin
            for (int k = 0; k < cil_pkg::NUM_SETS; k++)
            begin
                if (!cond_on[k])
                    sb_cnt[k] <= 16'h0;
                else if (sb_cnt[k] < standby_time)
                    sb_cnt[k] <= sb_cnt[k] + 16'h0001;
            end
        end
    end

    // Purge timer holds while purge start is off
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            purge_cnt <= 16'h0;
        else if (ce)
        begin
            if (main_st != cil_pkg::M_PURGING)
                purge_cnt <= 16'h0;
            else if (purge_start)
                purge_cnt <= purge_cnt + 16'h0001;
        end
    end

    // Sequencer state and registered outputs
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            main_st <= cil_pkg::M_IDLE;
            pilot_st <= cil_pkg::P_IDLE;
            mon <= '0;
            lockout <= 1'b0;
            regular_interlock <= 1'b0;
            pilot_permit <= 1'b0;
            irq_stat <= cil_pkg::IRQ_RST;
            irq <= 1'b0;
            prev_done <= 1'b0;
            prev_purged <= 1'b0;
            prev_pdone <= 1'b0;
        end
        else if (ce)
        begin
            main_st <= next_main;
            pilot_st <= next_pilot;
            mon.main_air_off_confirmed <= (next_main == cil_pkg::M_OFFOK);
            mon.main_air_check_done <= (next_main >= cil_pkg::M_CHECKED);
            mon.purge_in_progress <= (next_main == cil_pkg::M_PURGING);
            mon.purge_complete <= purged_n;
            mon.pilot_air_off_confirmed <= (next_pilot == cil_pkg::P_OFFOK);
            mon.pilot_air_check_done <= pdone_n;
            mon.pilot_air_alarm <= next_alarm;
            lockout <= next_lockout;
            regular_interlock <= next_ril;
            pilot_permit <= next_permit;
            irq_stat <= next_stat;
            irq <= |(next_stat & irq_mask);
            prev_done <= (next_main == cil_pkg::M_CHECKED);
            prev_purged <= purged_n;
            prev_pdone <= pdone_n;
        end
    end

    // Checks kept beside the logic
    a_cond_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        trip_now |-> (cond_on & supervise) != 5'h0)
        else $error("trip while no condition set supervising");
    a_standby_wait: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(cond_on[0]) && standby_time != 16'h0 |-> !supervise[0])
        else $error("supervision armed without standby");
    a_main_offok: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && main_st == cil_pkg::M_IDLE && startup && !main_air_sw && !next_lockout
        |=> mon.main_air_off_confirmed)
        else $error("main off confirm missing");
    a_main_check: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && main_st == cil_pkg::M_OFFOK && blower_sync && main_air_sw && startup
        && !next_lockout |=> mon.main_air_check_done && !mon.main_air_off_confirmed)
        else $error("main check done missing");
    a_purge_begin: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && main_st == cil_pkg::M_CHECKED && purge_start && main_air_sw && startup
        && !next_lockout |=> mon.purge_in_progress && !mon.purge_complete)
        else $error("purge did not begin");
    a_purge_count: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && main_st == cil_pkg::M_PURGING && purge_start && !purge_last
        |=> purge_cnt == $past(purge_cnt) + 16'h0001)
        else $error("purge timing stalled");
    a_pilot_check: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && pilot_st == cil_pkg::P_OFFOK && pilot_sync && pilot_sw && startup
        && !next_lockout |=> mon.pilot_air_check_done)
        else $error("pilot check done missing");
    a_permit_pilot: assert property (@(posedge hclk) disable iff (!hresetn)
        (pilot_permit || regular_interlock) && regular |-> mon.pilot_air_check_done
        && mon.purge_complete)
        else $error("permission without completed checks");
    a_pilot_loss: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && regular_interlock && !pilot_sw
        |=> lockout && !regular_interlock && mon.pilot_air_alarm)
        else $error("pilot air loss not locked out");
    a_lock_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        lockout && !cmd_wr |=> lockout && !pilot_permit)
        else $error("lockout released without reset");
endmodule : interlock_supervisor

// ---- testbench/host_model.sv ----
// Purpose: Host controller model that runs the main and pilot blowers
// Assumes: Reacts to the supervisor's monitor outputs on hclk
// Notes: resp_dly slows the main blower reply; pilot_loss opens the pilot switch on command
`timescale 1ns/1ps
module host_model
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    input wire logic pilot_go,
    input wire logic pilot_loss,
    input wire logic [3:0] resp_dly,
    input wire cil_pkg::mon_s mon,
    output logic main_sw,
    output logic blower_sync,
    output logic pilot_sync,
    output logic pilot_sw
);
    logic [3:0] dly_cnt; // Cycles spent seeing the main off confirmation

    // Host sequencing; withdrawing startup stops both blowers and opens both switches
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dly_cnt <= 4'h0;
            main_sw <= 1'b0;
            blower_sync <= 1'b0;
            pilot_sync <= 1'b0;
            pilot_sw <= 1'b0;
        end
        else if (!run)
        begin
            dly_cnt <= 4'h0;
            main_sw <= 1'b0;
            blower_sync <= 1'b0;
            pilot_sync <= 1'b0;
            pilot_sw <= 1'b0;
        end
        else
        begin
            // Wait a chosen time after confirmation, as a slow host would
            dly_cnt <= mon.main_air_off_confirmed ? dly_cnt + 4'h1 : 4'h0;
            if (mon.main_air_off_confirmed && dly_cnt == resp_dly)
                blower_sync <= 1'b1;
            // Air pressure only builds once the blower runs
            if (blower_sync)
                main_sw <= 1'b1;
            // Pilot blower starts only after its off confirmation
            if (pilot_go && mon.pilot_air_off_confirmed)
                pilot_sync <= 1'b1;
            pilot_sw <= pilot_sync && !pilot_loss;
        end
    end
endmodule : host_model

// ---- testbench/testbench.sv ----
// Purpose: Self-checking bench for the interlock supervisor
// Assumes: Single AHB-Lite master, one clock at 200 MHz
// Notes: Terminals 0, 2 and 3 come from the host model, the rest from the bench
`timescale 1ns/1ps
module testbench;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [15:0] tb_terms = 16'h0000; // Bench-driven terminals
    logic startup = 1'b0;
    logic pilot_go = 1'b0;
    logic pilot_loss = 1'b0;
    logic [3:0] resp_dly = 4'h6; // Slow host first
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    cil_pkg::mon_s mon;
    logic regular_interlock;
    logic pilot_permit;
    logic lockout;
    logic irq;
    logic main_sw;
    logic blower_sync;
    logic pilot_sync;
    logic pilot_sw;
    logic [15:0] term_in;
    int n_mismatch = 0;
    int n_compared = 0;

    // Host owns sync and pilot switch pins, bench owns purge start and interlocks
    assign term_in = {tb_terms[15:4], pilot_sw, pilot_sync, tb_terms[1], blower_sync};

    // 5 ns clock
    always #2.5 hclk = ~hclk;

    interlock_supervisor #(.N_IN(16)) dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .term_in(term_in), .startup(startup), .main_air_sw(main_sw),
        .mon(mon), .regular_interlock(regular_interlock), .pilot_permit(pilot_permit),
        .lockout(lockout), .irq(irq));

    host_model host (.hclk(hclk), .hresetn(hresetn), .run(startup), .pilot_go(pilot_go),
        .pilot_loss(pilot_loss), .resp_dly(resp_dly), .mon(mon), .main_sw(main_sw),
        .blower_sync(blower_sync), .pilot_sync(pilot_sync), .pilot_sw(pilot_sw));

    // Single comparison point
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t ns seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task check_bit(input logic seen, input logic exp);
        check({31'h0, seen}, {31'h0, exp});
    endtask : check_bit

    task cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask : cyc

    // Sample hready at each edge; only the watchdog ends a stuck wait
    task wait_ready();
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
    endtask : wait_ready

    // One single word transfer: address phase, then data phase
    task bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
             output logic [31:0] rdv);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h000000, ofs};
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rdv = hrdata;
    endtask : bus

    task wr(input logic [7:0] ofs, input logic [31:0] wd);
        logic [31:0] d;
        bus(1'b1, ofs, wd, d);
    endtask : wr

    task rchk(input logic [7:0] ofs, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, ofs, 32'h0000_0000, d);
        check(d, exp);
        // Slave answers every transfer with OKAY
        check_bit(hresp, 1'b0);
    endtask : rchk

    // Monitor bit index counts from the alarm at 0 up to main off at 6
    task wait_mon(input int i);
        int n;
        n = 0;
        while (mon[i] !== 1'b1 && n < 200)
        begin
            @(posedge hclk);
            n++;
        end
        check_bit(mon[i], 1'b1);
    endtask : wait_mon

    task end_sim();
        if (n_mismatch == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim

    // Watchdog; the whole run needs only a few hundred cycles
    initial
    begin
        #200000;
        n_mismatch++;
        end_sim();
    end

    // Main sequence
    initial
    begin
        int c;
        cyc(16);
        hresetn <= 1'b1;
        cyc(1);
        rchk(cil_pkg::OFS_STANDBY, 32'h0000_0010);
        rchk(cil_pkg::OFS_PURGE, 32'h0000_0020);
        rchk(cil_pkg::OFS_IRQ_MASK, 32'h0000_0000);
        rchk(8'h40, 32'h0000_0000);
        // Blower sync also on terminal 9, which stays low: lowest terminal must win
        wr(cil_pkg::OFS_FUNC0, 32'h0002_0201);
        wr(cil_pkg::OFS_FUNC1, 32'h0008_0004);
        wr(cil_pkg::OFS_COND_SRC, 32'h0008_0004);
        // Terminals 5 and 6 under set A, terminal 7 under set E
        wr(cil_pkg::OFS_ASSIGN_LO, 32'h00A4_8000);
        rchk(cil_pkg::OFS_ASSIGN_LO, 32'h00A4_8000);
        wr(cil_pkg::OFS_STANDBY, 32'h0000_0004);
        wr(cil_pkg::OFS_PURGE, 32'h0000_0004);
        wr(cil_pkg::OFS_IRQ_MASK, 32'h0000_000F);
        // Interlocks open while their conditions are off
        cyc(12);
        check_bit(lockout, 1'b0);
        for (int i = 5; i < 8; i++)
        begin
            c = (i == 7) ? 8 : 4;
            tb_terms <= (16'h00E0 & ~(16'h0001 << i)) | (16'h0001 << c);
            cyc(4);
            check_bit(lockout, 1'b0);
            cyc(4);
            check_bit(lockout, 1'b1);
            check_bit(irq, 1'b1);
            rchk(cil_pkg::OFS_IRQ_STAT, 32'h0000_0001);
            wr(cil_pkg::OFS_IRQ_STAT, 32'h0000_0001);
            cyc(2);
            check_bit(irq, 1'b0);
            // Reset refused while the trip persists
            wr(cil_pkg::OFS_CMD, 32'h0000_0001);
            cyc(2);
            check_bit(lockout, 1'b1);
            tb_terms <= 16'h00E0;
            cyc(2);
            wr(cil_pkg::OFS_CMD, 32'h0000_0001);
            cyc(2);
            check_bit(lockout, 1'b0);
        end
        // Regular module: main air, paused purge, then pilot air
        wr(cil_pkg::OFS_IRQ_MASK, 32'h0000_0000);
        startup <= 1'b1;
        wait_mon(6);
        wait_mon(5);
        tb_terms[1] <= 1'b1;
        wait_mon(4);
        cyc(1);
        tb_terms[1] <= 1'b0;
        cyc(10);
        check_bit(mon.purge_complete, 1'b0);
        check_bit(mon.pilot_air_off_confirmed, 1'b1);
        tb_terms[1] <= 1'b1;
        wait_mon(3);
        check_bit(pilot_permit, 1'b0);
        check_bit(regular_interlock, 1'b0);
        pilot_go <= 1'b1;
        wait_mon(1);
        cyc(2);
        check_bit(pilot_permit, 1'b1);
        check_bit(regular_interlock, 1'b1);
        // Events latched while masked, then seen once unmasked
        check_bit(irq, 1'b0);
        rchk(cil_pkg::OFS_IRQ_STAT, 32'h0000_000E);
        wr(cil_pkg::OFS_IRQ_MASK, 32'h0000_000F);
        cyc(2);
        check_bit(irq, 1'b1);
        wr(cil_pkg::OFS_IRQ_STAT, 32'h0000_000E);
        cyc(2);
        check_bit(irq, 1'b0);
        // Pilot air lost while zones burn
        pilot_loss <= 1'b1;
        wait_mon(0);
        check_bit(lockout, 1'b1);
        check_bit(regular_interlock, 1'b0);
        wr(cil_pkg::OFS_CMD, 32'h0000_0001);
        cyc(2);
        check_bit(lockout, 1'b1);
        pilot_loss <= 1'b0;
        cyc(3);
        wr(cil_pkg::OFS_CMD, 32'h0000_0001);
        cyc(2);
        check_bit(lockout, 1'b0);
        // Zone module: no pilot air check, prompt host
        startup <= 1'b0;
        pilot_go <= 1'b0;
        resp_dly <= 4'h0;
        cyc(3);
        wr(cil_pkg::OFS_CTRL, 32'h0000_0001);
        startup <= 1'b1;
        wait_mon(3);
        cyc(2);
        check_bit(pilot_permit, 1'b1);
        check_bit(regular_interlock, 1'b0);
        end_sim();
    end
endmodule : testbench
